// [scd_cfg.svh]
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// ==========================================================
// register select codes (low three bits of a word)
`define SCD_SEL_FREQ        3'h0
`define SCD_SEL_REF         3'h2
`define SCD_SEL_CLKDIV      3'h3
`define SCD_SEL_OUT         3'h4
`define SCD_SEL_LDPIN       3'h5
`define SCD_WORD_RESET      32'h0000_0000

// ==========================================================
// reference and charge-pump control fields
`define SCD_REF_DOUBLER     25
`define SCD_REF_HALVER      24
`define SCD_RCOUNT_HI       23
`define SCD_RCOUNT_LO       14
`define SCD_DOUBLE_BUF      13
`define SCD_LD_FUNC         8
`define SCD_LD_PREC         7
`define SCD_POWER_DOWN      5
`define SCD_CP_TRISTATE     4
`define SCD_CNT_RESET       3

// ==========================================================
// clock-divider control fields
`define SCD_SLIP_RED        18
`define SCD_CDMODE_HI       16
`define SCD_CDMODE_LO       15
`define SCD_CDVAL_HI        14
`define SCD_CDVAL_LO        3
`define SCD_CDMODE_OFF      2'h0
`define SCD_CDMODE_FAST     2'h1
`define SCD_CDMODE_RESYNC   2'h2

// ==========================================================
// output-stage control fields
`define SCD_FB_DIRECT       23
`define SCD_DIVSEL_HI       22
`define SCD_DIVSEL_LO       20
`define SCD_BSDIV_HI        19
`define SCD_BSDIV_LO        12
`define SCD_OSC_PD          11
`define SCD_MUTE_LOCK       10
`define SCD_AUX_SEL         9
`define SCD_AUX_EN          8
`define SCD_AUX_PWR_HI      7
`define SCD_AUX_PWR_LO      6
`define SCD_OUT_EN          5
`define SCD_OUT_PWR_HI      4
`define SCD_OUT_PWR_LO      3

// ==========================================================
// lock-detect pin field and codes
`define SCD_LDPIN_HI        23
`define SCD_LDPIN_LO        22
`define SCD_LDPIN_LOW       2'h0
`define SCD_LDPIN_LOCK      2'h1
`define SCD_LDPIN_HIGH      2'h3

// ==========================================================
// lock detection counts and windows
`define SCD_FRAC_LD_COUNT   6'd40
`define SCD_INT_LD_COUNT    6'd5
`define SCD_WIN_WIDE_NS     8'd10
`define SCD_WIN_NARROW_NS   8'd6

`endif

// [scd_pkg.sv]
package scd_pkg;

    // output stage controls towards the analog side
    typedef struct packed {
        logic       oscEnable;
        logic       fbDirect;
        logic [2:0] divSelect;
        logic       primaryEnable;
        logic [1:0] primaryPower;
        logic       auxEnable;
        logic       auxFundamental;
        logic [1:0] auxPower;
    } scdOutStage_type;

    // loop controls towards the charge pump and counters
    typedef struct packed {
        logic cpTristate;
        logic counterReset;
        logic slipReduction;
        logic fastLockActive;
        logic resyncPulse;
    } scdLoopCtl_type;

    // clock divider timer states
    typedef enum logic [2:0] {
        TM_IDLE   = 3'b001,
        TM_FAST   = 3'b010,
        TM_RESYNC = 3'b100
    } scdTimer_type;

endpackage

// [scd_lock_detect.sv]
`timescale 1ns/1ps
`include "scd_cfg.svh"

module scd_lock_detect
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // control
    input  wire logic       clear,
    input  wire logic       integerMode,
    input  wire logic       precision,
    // phase detector
    input  wire logic       pfdTick,
    input  wire logic [7:0] phaseErrorNs,
    // status
    output logic            locked
);
    import scd_pkg::*;

    logic [5:0] goodCount_r;
    logic [7:0] window;
    logic [5:0] target;

    // window and count per mode and precision
    always_comb
    begin
        if (integerMode)
        begin
            window = precision ? `SCD_WIN_WIDE_NS : `SCD_WIN_NARROW_NS;
            target = `SCD_INT_LD_COUNT;
        end
        else
        begin
            window = precision ? `SCD_WIN_NARROW_NS : `SCD_WIN_WIDE_NS;
            target = `SCD_FRAC_LD_COUNT;
        end
    end

    // consecutive good cycle counter
    always_ff @(posedge clk_sys)
    begin
        if (rst || clear)
        begin
            goodCount_r <= 6'h00;
            locked      <= 1'b0;
        end
        else if (pfdTick)
        begin
            if (phaseErrorNs <= window)
            begin
                if (goodCount_r >= target - 6'h01)
                    locked <= 1'b1;
                else
                    goodCount_r <= goodCount_r + 6'h01;
            end
            else
            begin
                goodCount_r <= 6'h00;
                locked      <= 1'b0;
            end
        end
    end

endmodule // scd_lock_detect

// [scd_control.sv]
`timescale 1ns/1ps
`include "scd_cfg.svh"
// Operation
// - doubler bit makes both reference edges count
// - select 010 loads reference control register
// - selects 011, 100, 101 load remaining registers
// - halver toggle divides counter output by two
// - ten-bit reference counter divides 1 to 1023
// - double buffer delays divider select update
// - function bit picks integer or fractional detect
// - fractional: 40 cycles within 10/6 ns
// - integer: five cycles within 6/10 ns
// - power-down bit enters and leaves power-down
// - power-down forces counters, oscillator, pump, outputs
// - serial register keeps working in power-down
// - tri-state bit floats the charge pump
// - counter-reset bit holds both counters reset
// - slip-reduction bit enables cycle slip reduction
// - mode field: resync, fast lock or off
// - twelve-bit value sets timer count
// - feedback select picks oscillator or divider
// - three-bit field picks output divider ratio
// - eight-bit band-select clock divider
// - mute keeps primary output off until lock
// - output-stage register holds enables and powers
// - lock pin field picks pin drive

module scd_control
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // serial programming pins
    input  wire logic                 serialClock,
    input  wire logic                 serialData,
    input  wire logic                 latchEnable,
    // reference and phase detector
    input  wire logic                 reference_input,
    input  wire logic [7:0]           phaseErrorNs,
    // timing outputs
    output logic                      pfdClock,
    output logic                      pfdTick,
    output logic                      bandSelectTick,
    // analog controls
    output scd_pkg::scdOutStage_type  outStage,
    output scd_pkg::scdLoopCtl_type   loopCtl,
    // status
    output logic                      powerDown,
    output logic                      lockDetected,
    output logic                      lockPin
);
    import scd_pkg::*;

    // ==========================================================
    // serial input register
    logic [2:0]  sclkSync_r;
    logic [1:0]  dataSync_r;
    logic [2:0]  leSync_r;
    logic [31:0] shift_r;
    logic        latchPulse;
    logic        freqLatch;

    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sclkSync_r <= 3'h0;
            dataSync_r <= 2'h0;
            leSync_r   <= 3'h0;
        end
        else
        begin
            sclkSync_r <= {sclkSync_r[1:0], serialClock};
            dataSync_r <= {dataSync_r[0], serialData};
            leSync_r   <= {leSync_r[1:0], latchEnable};
        end
    end

    // shift in on serial clock rise, msb first
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            shift_r <= `SCD_WORD_RESET;
        else if (sclkSync_r[1] && !sclkSync_r[2])
            shift_r <= {shift_r[30:0], dataSync_r[1]};
    end

    assign latchPulse = leSync_r[1] && !leSync_r[2];
    assign freqLatch  = latchPulse && (shift_r[2:0] == `SCD_SEL_FREQ);

    // ==========================================================
    // control registers, kept through power-down
    logic [31:0] refCtrl_r;
    logic [31:0] clkDivCtrl_r;
    logic [31:0] outCtrl_r;
    logic [31:0] lockPinCtrl_r;
    logic [2:0]  activeDivSel_r;

    // route latched word by select bits
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            refCtrl_r     <= `SCD_WORD_RESET;
            clkDivCtrl_r  <= `SCD_WORD_RESET;
            outCtrl_r     <= `SCD_WORD_RESET;
            lockPinCtrl_r <= `SCD_WORD_RESET;
        end
        else if (latchPulse)
        begin
            case (shift_r[2:0])
                `SCD_SEL_REF:    refCtrl_r     <= shift_r;
                `SCD_SEL_CLKDIV: clkDivCtrl_r  <= shift_r;
                `SCD_SEL_OUT:    outCtrl_r     <= shift_r;
                `SCD_SEL_LDPIN:  lockPinCtrl_r <= shift_r;
                default:         ;
            endcase
        end
    end

    // divider select, direct or held until a frequency word
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            activeDivSel_r <= 3'h0;
        else if (!refCtrl_r[`SCD_DOUBLE_BUF])
            activeDivSel_r <= outCtrl_r[`SCD_DIVSEL_HI:`SCD_DIVSEL_LO];
        else if (freqLatch)
            activeDivSel_r <= outCtrl_r[`SCD_DIVSEL_HI:`SCD_DIVSEL_LO];
    end

    // ==========================================================
    // reference path
    logic [2:0] refSync_r;
    logic       refPulse;
    logic       countHold;
    logic [9:0] rCount_r;
    logic [9:0] rRatio;
    logic       rOut;
    logic       halver_r;

    assign powerDown = refCtrl_r[`SCD_POWER_DOWN];
    assign countHold = refCtrl_r[`SCD_CNT_RESET] || powerDown;

    // reference pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            refSync_r <= 3'h0;
        else
            refSync_r <= {refSync_r[1:0], reference_input};
    end

    // falling edge only, or both edges when doubled
    assign refPulse = refCtrl_r[`SCD_REF_DOUBLER] ? (refSync_r[1] != refSync_r[2])
                                                  : (!refSync_r[1] && refSync_r[2]);

    // zero ratio is not allowed, run it as one
    assign rRatio = (refCtrl_r[`SCD_RCOUNT_HI:`SCD_RCOUNT_LO] == 10'h000) ? 10'h001
                  : refCtrl_r[`SCD_RCOUNT_HI:`SCD_RCOUNT_LO];
    assign rOut   = refPulse && !countHold && (rCount_r >= rRatio - 10'h001);

    // ten-bit reference counter
    always_ff @(posedge clk_sys)
    begin
        if (rst || countHold)
            rCount_r <= 10'h000;
        else if (rOut)
            rCount_r <= 10'h000;
        else if (refPulse)
            rCount_r <= rCount_r + 10'h001;
    end

    // divide-by-two toggle after the counter
    always_ff @(posedge clk_sys)
    begin
        if (rst || countHold)
            halver_r <= 1'b0;
        else if (rOut)
            halver_r <= !halver_r;
    end

    assign pfdTick  = refCtrl_r[`SCD_REF_HALVER] ? (rOut && !halver_r) : rOut;
    assign pfdClock = halver_r;

    // ==========================================================
    // band select clock divider
    logic [7:0] bsCount_r;
    logic [7:0] bsRatio;

    assign bsRatio = outCtrl_r[`SCD_BSDIV_HI:`SCD_BSDIV_LO];

    // divides reference counter output, zero bypasses
    always_ff @(posedge clk_sys)
    begin
        if (rst || countHold)
        begin
            bsCount_r      <= 8'h00;
            bandSelectTick <= 1'b0;
        end
        else
        begin
            bandSelectTick <= 1'b0;
            if (rOut)
            begin
                if (bsRatio == 8'h00 || bsCount_r >= bsRatio - 8'h01)
                begin
                    bsCount_r      <= 8'h00;
                    bandSelectTick <= 1'b1;
                end
                else
                    bsCount_r <= bsCount_r + 8'h01;
            end
        end
    end

    // ==========================================================
    // clock divider timer
    scdTimer_type timerState_r;
    scdTimer_type timerState_nxt;
    logic [11:0]  timerCount_r;
    logic [1:0]   cdMode;

    assign cdMode = clkDivCtrl_r[`SCD_CDMODE_HI:`SCD_CDMODE_LO];

    // next state of timer
    always_comb
    begin
        timerState_nxt = timerState_r;
        case (timerState_r)
            TM_IDLE:
            begin
                if (freqLatch && cdMode == `SCD_CDMODE_FAST)
                    timerState_nxt = TM_FAST;
                else if (freqLatch && cdMode == `SCD_CDMODE_RESYNC)
                    timerState_nxt = TM_RESYNC;
            end
            TM_FAST, TM_RESYNC:
            begin
                if (pfdTick && timerCount_r == 12'h000)
                    timerState_nxt = TM_IDLE;
            end
            default:
                timerState_nxt = TM_IDLE;
        endcase
        if (powerDown || cdMode == `SCD_CDMODE_OFF)
            timerState_nxt = TM_IDLE;
    end

    // timer state register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timerState_r <= TM_IDLE;
        else
            timerState_r <= timerState_nxt;
    end

    // timeout counter in phase detector cycles
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timerCount_r <= 12'h000;
        else if (timerState_r == TM_IDLE)
            timerCount_r <= clkDivCtrl_r[`SCD_CDVAL_HI:`SCD_CDVAL_LO];
        else if (pfdTick && timerCount_r != 12'h000)
            timerCount_r <= timerCount_r - 12'h001;
    end

    // ==========================================================
    // digital lock detection
    scd_lock_detect u_lock_detect
    (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .clear        (countHold),
        .integerMode  (refCtrl_r[`SCD_LD_FUNC]),
        .precision    (refCtrl_r[`SCD_LD_PREC]),
        .pfdTick      (pfdTick),
        .phaseErrorNs (phaseErrorNs),
        .locked       (lockDetected)
    );

    // ==========================================================
    // loop and output stage controls, registered
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            loopCtl.cpTristate     <= 1'b1;
            loopCtl.counterReset   <= 1'b1;
            loopCtl.slipReduction  <= 1'b0;
            loopCtl.fastLockActive <= 1'b0;
            loopCtl.resyncPulse    <= 1'b0;
        end
        else
        begin
            loopCtl.cpTristate     <= refCtrl_r[`SCD_CP_TRISTATE] || powerDown;
            loopCtl.counterReset   <= countHold;
            loopCtl.slipReduction  <= clkDivCtrl_r[`SCD_SLIP_RED];
            loopCtl.fastLockActive <= (timerState_nxt == TM_FAST);
            loopCtl.resyncPulse    <= (timerState_r == TM_RESYNC)
                                      && (timerState_nxt == TM_IDLE) && !powerDown
                                      && (cdMode == `SCD_CDMODE_RESYNC);
        end
    end

    // output stage fields with power-down and mute gating
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            outStage <= '0;
        else
        begin
            outStage.oscEnable      <= !outCtrl_r[`SCD_OSC_PD] && !powerDown;
            outStage.fbDirect       <= outCtrl_r[`SCD_FB_DIRECT];
            outStage.divSelect      <= activeDivSel_r;
            outStage.primaryEnable  <= outCtrl_r[`SCD_OUT_EN] && !powerDown
                                       && (!outCtrl_r[`SCD_MUTE_LOCK] || lockDetected);
            outStage.primaryPower   <= outCtrl_r[`SCD_OUT_PWR_HI:`SCD_OUT_PWR_LO];
            outStage.auxEnable      <= outCtrl_r[`SCD_AUX_EN] && !powerDown;
            outStage.auxFundamental <= outCtrl_r[`SCD_AUX_SEL];
            outStage.auxPower       <= outCtrl_r[`SCD_AUX_PWR_HI:`SCD_AUX_PWR_LO];
        end
    end

    // lock detect pin drive
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            lockPin <= 1'b0;
        else
        begin
            case (lockPinCtrl_r[`SCD_LDPIN_HI:`SCD_LDPIN_LO])
                `SCD_LDPIN_LOCK: lockPin <= lockDetected;
                `SCD_LDPIN_HIGH: lockPin <= 1'b1;
                default:         lockPin <= 1'b0;
            endcase
        end
    end

endmodule // scd_control

// [scd_control_asserts.sv]
`timescale 1ns/1ps

// ==========================================================
// checker on the control block ports
module scd_control_asserts
(
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst,
    // watched outputs
    input wire logic                    pfdTick,
    input wire logic                    bandSelectTick,
    input wire scd_pkg::scdOutStage_type outStage,
    input wire scd_pkg::scdLoopCtl_type  loopCtl,
    input wire logic                    powerDown,
    input wire logic                    lockDetected
);
    import scd_pkg::*;

    // one clock domain for all properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_tick_single: assert property (pfdTick |=> !pfdTick)
        else $error("phase detector tick wider than one cycle");
    chk_cnt_hold: assert property (loopCtl.counterReset |-> !$past(pfdTick))
        else $error("tick while counters held");
    chk_pd_pump: assert property (powerDown [*2] |-> loopCtl.cpTristate)
        else $error("pump driven in power-down");
    chk_pd_outs: assert property (powerDown [*2] |->
        !outStage.oscEnable && !outStage.primaryEnable)
        else $error("oscillator or output on in power-down");
    chk_pd_unlock: assert property (powerDown [*2] |-> !lockDetected)
        else $error("lock shown in power-down");
    chk_lock_rise: assert property ($rose(lockDetected) |-> $past(pfdTick))
        else $error("lock rose without a tick");
    chk_lock_fall: assert property ($fell(lockDetected) |->
        $past(pfdTick) || powerDown || loopCtl.counterReset)
        else $error("lock fell without cause");
    chk_band_single: assert property (bandSelectTick |=> !bandSelectTick)
        else $error("band select tick wider than one cycle");
    chk_resync_one: assert property (loopCtl.resyncPulse |=> !loopCtl.resyncPulse)
        else $error("resync pulse wider than one cycle");
endmodule // scd_control_asserts

bind scd_control scd_control_asserts u_chk (.clk_sys, .rst, .pfdTick, .bandSelectTick,
    .outStage, .loopCtl, .powerDown, .lockDetected);

// [scd_host_model.sv]
`timescale 1ns/1ps

// ==========================================================
// host side of the three-wire programming port
module scd_host_model
(
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic     serialClock,
    output logic     serialData,
    output logic     latchEnable
);
    logic busy;

    // idle pins
    initial
    begin
        serialClock = 0;
        serialData = 0;
        latchEnable = 0;
        busy = 0;
    end

    // released data line keeps changing so a stale bit never looks valid
    always @(negedge clk_sys)
        if (!busy) serialData <= ~serialData;

    // hold every pin level four system cycles
    task automatic hold4;
        repeat (4) @(negedge clk_sys);
    endtask

    // one whole word, clock still outside the frame
    task automatic sendWord(input logic [31:0] word);
        busy = 1;
        @(negedge clk_sys);
        for (int i = 31; i >= 0; i--)
        begin
            serialData = word[i];
            hold4();
            serialClock = 1;
            hold4();
            serialClock = 0;
        end
        hold4();
        latchEnable = 1;
        hold4();
        latchEnable = 0;
        busy = 0;
        hold4();
    endtask
endmodule // scd_host_model

// [scd_control_test.sv]
`timescale 1ns/1ps

// ==========================================================
// testbench of the control register block
module scd_control_test;
    import scd_pkg::*;
    logic            clk_sys = 0;
    logic            rst = 1;
    logic            reference_input = 0;
    logic [7:0]      phaseErrorNs = 8'hff;
    logic            serialClock, serialData, latchEnable;
    logic            pfdClock, pfdTick, bandSelectTick, powerDown, lockDetected, lockPin;
    scdOutStage_type outStage;
    scdLoopCtl_type  loopCtl;
    int              n_fail = 0, n_checks = 0, n, c, refCnt = 0;
    int              tickCnt = 0, fastCnt = 0, resyncTick = 0, latchTick = 0;
    int              per[5] = '{16, 8, 32, 8, 8184};
    logic [31:0]     refW[5] = '{32'h0000_8002, 32'h0200_8002, 32'h0100_8002,
                                 32'h0000_4002, 32'h00ff_c002};
    logic [31:0]     ldW[6] = '{32'h8002, 32'h8082, 32'h8082, 32'h8102, 32'h8102, 32'h8182};
    logic [7:0]      ldE[6] = '{8'h0a, 8'h06, 8'h07, 8'h06, 8'h07, 8'h0a};
    int              ldN[6] = '{40, 40, 0, 5, 0, 5};

    // clock and reference (one reference edge every four cycles)
    always #12.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys)
    begin
        refCnt <= refCnt + 1;
        if (refCnt % 4 == 3) reference_input <= ~reference_input;
    end

    // background tick bookkeeping
    always @(negedge clk_sys)
    begin
        if (pfdTick) tickCnt++;
        if (pfdTick && loopCtl.fastLockActive) fastCnt++;
        if (loopCtl.resyncPulse) resyncTick = tickCnt;
    end
    always @(posedge latchEnable) latchTick = tickCnt;

    scd_control dut (.clk_sys, .rst, .serialClock, .serialData, .latchEnable,
        .reference_input, .phaseErrorNs, .pfdClock, .pfdTick, .bandSelectTick,
        .outStage, .loopCtl, .powerDown, .lockDetected, .lockPin);
    scd_host_model host (.clk_sys, .serialClock, .serialData, .latchEnable);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic timeout;
        n_fail++;
        $display("FAIL %0t wait bound used up", $time);
        results();
    endtask

    task automatic wr(input logic [31:0] w);
        host.sendWord(w);
        repeat (8) @(negedge clk_sys);
    endtask

    // cycles from one tick to the next, phase detector or band select
    task automatic gap(output int cyc, input bit band = 1'b0);
        int i;
        for (i = 0; i < 9000 && !(band ? bandSelectTick : pfdTick); i++)
            @(negedge clk_sys);
        if (i == 9000) timeout();
        @(negedge clk_sys);
        for (cyc = 1; cyc < 9000 && !(band ? bandSelectTick : pfdTick); cyc++)
            @(negedge clk_sys);
        if (cyc == 9000) timeout();
    endtask

    // good ticks needed before lock, 0 if none within 45
    task automatic lockRun(input logic [31:0] w, input logic [7:0] e, input int exp);
        int t;
        int k;
        t = 0;
        phaseErrorNs = 8'hff;
        wr(w);
        gap(k);
        @(negedge clk_sys);
        phaseErrorNs = e;
        for (k = 0; k < 2000 && !lockDetected && t < 45; k++)
        begin
            @(negedge clk_sys);
            if (pfdTick && !lockDetected) t++;
        end
        if (k == 2000) timeout();
        check(lockDetected ? t : 0, exp);
    endtask

    // hang guard
    initial
    begin
        repeat (90000) @(negedge clk_sys);
        timeout();
    end

    // main sequence
    initial
    begin
        repeat (12) @(negedge clk_sys);
        check(outStage, 12'h000);
        check(loopCtl, 5'h18);
        check(lockPin, 1'b0);
        rst = 0;
        repeat (4) @(negedge clk_sys);
        $display("test reset done");
        wr(32'h0000_0005);
        wr(32'h00d0_03bc);
        wr(32'h0000_0003);
        wr(32'h0000_8002);
        wr(32'h0000_0000);
        check(outStage, 12'hefe);
        check(loopCtl, 5'h00);
        foreach (ldN[i])
            if (i > 0 && i < 4)
            begin
                wr(32'(i == 1 ? 1 : i + 4));
                check(outStage, 12'hefe);
            end
        $display("test decode done");
        foreach (per[i])
        begin
            wr(refW[i]);
            gap(c);
            gap(c);
            check(c, per[i]);
            if (i == 2) check(pfdClock, 1'b0);
        end
        $display("test reference done");
        wr(32'h0000_800a);
        check(loopCtl.counterReset, 1'b1);
        n = 0;
        repeat (100)
        begin
            @(negedge clk_sys);
            n += pfdTick;
        end
        check(n, 0);
        check(pfdClock, 1'b0);
        wr(32'h0000_8012);
        check(loopCtl, 5'h10);
        wr(32'h0000_8022);
        check(powerDown, 1'b1);
        check({outStage.oscEnable, outStage.primaryEnable, loopCtl.cpTristate}, 3'h1);
        wr(32'h00c0_0005);
        check(lockPin, 1'b1);
        wr(32'h0000_8002);
        check(powerDown, 1'b0);
        check(outStage, 12'hefe);
        wr(32'h0000_a002);
        wr(32'h00e0_43bc);
        check(outStage.divSelect, 3'h5);
        gap(c, 1'b1);
        gap(c, 1'b1);
        check(c, 64);
        wr(32'h0000_0000);
        check(outStage.divSelect, 3'h6);
        $display("test power-down done");
        foreach (ldN[i]) lockRun(ldW[i], ldE[i], ldN[i]);
        for (int k = 0; k < 4; k++)
        begin
            wr(32'(k << 22) | 32'h5);
            check(lockPin, k[0]);
        end
        wr(32'h00d0_07bc);
        check(outStage.primaryEnable, 1'b1);
        phaseErrorNs = 8'hff;
        repeat (40) @(negedge clk_sys);
        check({lockDetected, outStage.primaryEnable}, 2'h0);
        $display("test lock done");
        wr(32'h0102_0002);
        wr(32'h0004_801b);
        check(loopCtl.slipReduction, 1'b1);
        gap(c);
        fastCnt = 0;
        wr(32'h0000_0000);
        repeat (700) @(negedge clk_sys);
        check(fastCnt, 4);
        wr(32'h0001_001b);
        gap(c);
        wr(32'h0000_0000);
        repeat (700) @(negedge clk_sys);
        check(resyncTick - latchTick, 4);
        $display("test timer done");
        results();
    end
endmodule // scd_control_test
